// >>> core/scl_pkg.sv
// Package for the strap configuration latch: map, strap fields, carriers
package scl_pkg;

  // Register byte offsets, one aligned 32-bit word each
  localparam logic [7:0] SCL_OFF_STRAP_STAT = 8'h00;
  localparam logic [7:0] SCL_OFF_CFG_STATUS = 8'h04;
  localparam logic [7:0] SCL_OFF_BOARD_ID = 8'h08;
  localparam logic [7:0] SCL_OFF_INT_PIN = 8'h0c;
  localparam logic [7:0] SCL_OFF_MEM_BAR = 8'h10;
  localparam logic [7:0] SCL_OFF_INT_CTRL = 8'h14;
  localparam logic [7:0] SCL_OFF_AUX_STAT = 8'h18;

  // Strap positions on the memory data bus
  localparam int SCL_POS_ALT_SELECT = 62;
  localparam int SCL_POS_ROM_REMAP = 61;
  localparam int SCL_POS_INT_ADV = 59;
  localparam int SCL_POS_LEGACY_OFF = 58;
  localparam int SCL_POS_CONN_SENSE = 57;
  localparam int SCL_POS_TEST = 55;
  localparam int SCL_POS_PREFETCH = 53;
  localparam int SCL_POS_DEV_DISABLE = 51;
  localparam int SCL_POS_MEM_TYPE = 48;
  localparam int SCL_POS_CS_EN = 47;
  localparam int SCL_POS_BUS_TYPE = 40;
  localparam int SCL_POS_PLL_GAIN = 38;
  localparam int SCL_POS_FLASH = 37;
  localparam int SCL_POS_MODULE_SPEED = 29;
  localparam int SCL_POS_VENDOR = 8;
  localparam int SCL_POS_DEV_LOW = 0;

  // Field positions inside the software registers
  localparam int SCL_BAR_PREFETCH_BIT = 3;
  localparam int SCL_INT_CTRL_EN_BIT = 0;

  // Interrupt pin register values
  localparam logic [7:0] SCL_INT_PIN_ADV = 8'h01;
  localparam logic [7:0] SCL_INT_PIN_NONE = 8'h00;

  // Memory type codes
  localparam logic [2:0] SCL_MEM_RESERVED = 3'h0;
  localparam logic [2:0] SCL_MEM_WRAM = 3'h1;
  localparam logic [2:0] SCL_MEM_SGRAM = 3'h2;
  localparam logic [2:0] SCL_MEM_SDRAM = 3'h3;
  localparam logic [2:0] SCL_MEM_HYPER = 3'h4;
  localparam logic [2:0] SCL_MEM_EDO = 3'h5;
  localparam logic [2:0] SCL_MEM_FPDRAM = 3'h6;
  localparam logic [2:0] SCL_MEM_OFF = 3'h7;

  // Expansion ROM window: 64K, top 8K folds onto the bottom
  localparam int SCL_ROM_AW = 16;
  localparam logic [2:0] SCL_ROM_TOP_8K = 3'h7;

  // Values after reset, before any strap is latched
  localparam logic [7:0] SCL_RST_INT_PIN = 8'h00;
  localparam logic [2:0] SCL_RST_MEM_TYPE = 3'h0;
  localparam logic [1:0] SCL_RST_PLL_GAIN = 2'h2;
  localparam logic [15:0] SCL_RST_VENDOR = 16'h0000;
  // Arbitrary neutral high byte for the board device code
  localparam logic [7:0] SCL_RST_DEV_HIGH = 8'h00;

  // Latch sequencing, one-hot
  typedef enum logic [1:0] {
    SCL_ST_WAIT = 2'b01,
    SCL_ST_HELD = 2'b10
  } scl_state_e;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } scl_bus_req_s;

  // Host side address inputs used for device select
  typedef struct packed {
    logic ad16;
    logic ad17;
    logic pci_select;
  } scl_host_sel_s;

endpackage : scl_pkg

// >>> core/scl_strap_latch.sv
// Power-up strap latch: captures straps and presents configuration state
//
// Operation
// - Accelerated port selects AD16 or AD17 by strap
// - Remap top 8K ROM when legacy display off
// - Interrupt pin register reads 01h or 00h
// - Interrupt output still works when not advertised
// - Legacy display disable strap turns portion off
// - Connector sense picks feature or multimedia mode
// - Test strap set enters test mode
// - Prefetch strap shows as BAR bit 3
// - Disable strap forces internal select to zero
// - Disabled device ignores and never drives host bus
// - Three-bit memory type decode table
// - Strapped memory type reads back inverted
// - Chip-select strap enables or floats chip selects
// - Bus type depends on strap and package
// - PLL gain strap maps to swapped gain code
// - Flash strap reports writable firmware flash fitted
// - Reserved strap bits are ignored
// - Capture three module speed strap bits
// - Board vendor code from strap or firmware
// - Low strap byte loads board device code low
// - Clock select strap picks PLL or bus clock
// - Latch straps at first host bus command
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
module scl_strap_latch (
  // Clock and bus reset
  input wire logic clk,
  input wire logic rstn,
  // Strap levels
  input wire logic [63:0] memory_data_bus_in,
  input wire logic bus_clock_choice_pin,
  input wire logic pkg_is_bga,
  // Host bus activity
  input wire logic host_cmd_start,
  input wire scl_pkg::scl_host_sel_s host_sel,
  input wire logic [scl_pkg::SCL_ROM_AW-1:0] rom_addr_in,
  input wire logic irq_event,
  // Register port
  input wire scl_pkg::scl_bus_req_s bus_req,
  output logic [31:0] bus_rdata,
  // Configuration outputs
  output logic straps_latched,
  output logic init_select,
  output logic host_respond_en,
  output logic host_bus_oe_n,
  output logic [scl_pkg::SCL_ROM_AW-1:0] rom_addr_out,
  output logic [7:0] interrupt_pin_value,
  output logic intr_req,
  output logic legacy_display_en,
  output logic feature_connector_mode,
  output logic multimedia_connector,
  output logic test_mode,
  output logic bar_prefetchable,
  output logic [2:0] mem_type,
  output logic mem_access_off,
  output logic mem_cs_oe_n,
  output logic bus_is_agp,
  output logic [1:0] pll_gain_code,
  output logic writable_flash_present,
  output logic [2:0] module_speed,
  output logic [15:0] board_vendor_code,
  output logic [15:0] board_device_code,
  output logic core_clk_from_pll
);
  import scl_pkg::*;

  // Module state apart from the output flops, in one record
  typedef struct packed {
    scl_state_e st;
    logic alt_select;
    logic rom_remap;
    logic interrupt_advertise_strap;
    logic legacy_off;
    logic connector_class_sense;
    logic test_mode_strap;
    logic prefetch;
    logic device_disable_strap;
    logic cs_en;
    logic bus_type_alt;
    logic [1:0] pll_gain_strap;
    logic flash;
    logic [2:0] speed;
    logic clk_choice;
    logic [2:0] config_status_word;
    logic [15:0] vendor;
    logic [15:0] device;
    logic int_src_en;
    logic init_sel;
    logic [SCL_ROM_AW-1:0] rom_addr;
    logic intr;
    logic [31:0] rdata;
  } scl_state_s;

  scl_state_s st_r;
  scl_state_s st_nxt;

  // Strap gain maps to the oscillator code with the MSB flipped
  function automatic logic [1:0] scl_gain_map(input logic [1:0] s);
    scl_gain_map = {~s[1], s[0]};
  endfunction : scl_gain_map

  // Accelerated port is native on BGA, PCI native on PQFP; strap swaps
  function automatic logic scl_agp(input logic bga, input logic alt);
    scl_agp = bga ^ alt;
  endfunction : scl_agp

  // Register word holding the latched strap summary
  function automatic logic [31:0] scl_strap_word(input scl_state_s s);
    scl_strap_word = {16'h0000, s.speed, s.flash, s.pll_gain_strap,
      s.bus_type_alt, s.cs_en, s.device_disable_strap, s.prefetch,
      s.test_mode_strap, s.connector_class_sense, s.legacy_off,
      s.interrupt_advertise_strap, s.rom_remap, s.alt_select};
  endfunction : scl_strap_word

  logic agp_now;
  logic [2:0] strap_mem;
  assign agp_now = scl_agp(pkg_is_bga, st_r.bus_type_alt);
  // Memory type straps arrive inverted into the status field
  assign strap_mem = ~memory_data_bus_in[SCL_POS_MEM_TYPE +: 3];

  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = 32'h0000_0000;

    // Straps are sampled once, at the first host command after reset.
    // Reserved positions 36..32 and 28..24 are never looked at.
    if (st_r.st == SCL_ST_WAIT && host_cmd_start) begin
      st_nxt.st = SCL_ST_HELD;
      st_nxt.alt_select = memory_data_bus_in[SCL_POS_ALT_SELECT];
      st_nxt.rom_remap = memory_data_bus_in[SCL_POS_ROM_REMAP];
      st_nxt.interrupt_advertise_strap =
        memory_data_bus_in[SCL_POS_INT_ADV];
      st_nxt.legacy_off = memory_data_bus_in[SCL_POS_LEGACY_OFF];
      st_nxt.connector_class_sense =
        memory_data_bus_in[SCL_POS_CONN_SENSE];
      st_nxt.test_mode_strap = memory_data_bus_in[SCL_POS_TEST];
      st_nxt.prefetch = memory_data_bus_in[SCL_POS_PREFETCH];
      st_nxt.device_disable_strap =
        memory_data_bus_in[SCL_POS_DEV_DISABLE];
      st_nxt.cs_en = memory_data_bus_in[SCL_POS_CS_EN];
      st_nxt.bus_type_alt = memory_data_bus_in[SCL_POS_BUS_TYPE];
      st_nxt.pll_gain_strap = memory_data_bus_in[SCL_POS_PLL_GAIN +: 2];
      st_nxt.flash = memory_data_bus_in[SCL_POS_FLASH];
      st_nxt.speed = memory_data_bus_in[SCL_POS_MODULE_SPEED +: 3];
      st_nxt.clk_choice = bus_clock_choice_pin;
      st_nxt.config_status_word = strap_mem;
      st_nxt.vendor = memory_data_bus_in[SCL_POS_VENDOR +: 16];
      st_nxt.device[7:0] = memory_data_bus_in[SCL_POS_DEV_LOW +: 8];
    end

    // Firmware writes: only the configurable fields take them, and
    // only after the latch so a strap capture cannot undo them.
    if (bus_req.wr && st_r.st == SCL_ST_HELD) begin
      case (bus_req.addr)
        SCL_OFF_CFG_STATUS: begin
          st_nxt.config_status_word = bus_req.wdata[2:0];
        end
        SCL_OFF_BOARD_ID: begin
          st_nxt.vendor = bus_req.wdata[15:0];
          st_nxt.device = bus_req.wdata[31:16];
        end
        SCL_OFF_INT_CTRL: begin
          st_nxt.int_src_en = bus_req.wdata[SCL_INT_CTRL_EN_BIT];
        end
        default: begin
        end
      endcase
    end

    // Reads answer in the next cycle; unmapped addresses read zero
    if (bus_req.rd) begin
      case (bus_req.addr)
        SCL_OFF_STRAP_STAT: begin
          st_nxt.rdata = scl_strap_word(st_r);
        end
        SCL_OFF_CFG_STATUS: begin
          st_nxt.rdata = {29'h0, st_r.config_status_word};
        end
        SCL_OFF_BOARD_ID: begin
          st_nxt.rdata = {st_r.device, st_r.vendor};
        end
        SCL_OFF_INT_PIN: begin
          st_nxt.rdata = {24'h00_0000, (st_r.interrupt_advertise_strap ?
            SCL_INT_PIN_NONE : SCL_INT_PIN_ADV)};
        end
        SCL_OFF_MEM_BAR: begin
          st_nxt.rdata = 32'h0000_0000;
          st_nxt.rdata[SCL_BAR_PREFETCH_BIT] = st_r.prefetch;
        end
        SCL_OFF_INT_CTRL: begin
          st_nxt.rdata = {31'h0, st_r.int_src_en};
        end
        SCL_OFF_AUX_STAT: begin
          st_nxt.rdata = {30'h0, agp_now,
            st_r.st == SCL_ST_HELD};
        end
        default: begin
          st_nxt.rdata = 32'h0000_0000;
        end
      endcase
    end

    // Internal device select: a disabled device never sees one,
    // so configuration cycles cannot wake it
    if (st_r.device_disable_strap) begin
      st_nxt.init_sel = 1'b0;
    end else if (agp_now) begin
      st_nxt.init_sel = st_r.alt_select ?
        host_sel.ad17 : host_sel.ad16;
    end else begin
      st_nxt.init_sel = host_sel.pci_select;
    end

    // Fold the top 8K of the ROM window onto the bottom
    st_nxt.rom_addr = rom_addr_in;
    if (st_r.rom_remap && st_r.legacy_off &&
        rom_addr_in[SCL_ROM_AW-1 -: 3] == SCL_ROM_TOP_8K) begin
      st_nxt.rom_addr[SCL_ROM_AW-1 -: 3] = 3'h0;
    end

    // Interrupt follows the programmed source, not the advertised pin
    st_nxt.intr = st_r.int_src_en && irq_event &&
      !st_r.device_disable_strap;

    // Enum safety: any illegal code falls back to waiting
    case (st_r.st)
      SCL_ST_WAIT: begin
      end
      SCL_ST_HELD: begin
      end
      default: begin
        st_nxt.st = SCL_ST_WAIT;
      end
    endcase
  end

  // State register; defaults mimic the internal pull-downs (all zero)
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
      st_r.st <= SCL_ST_WAIT;
      st_r.pll_gain_strap <= 2'h0;
      st_r.config_status_word <= SCL_RST_MEM_TYPE;
      st_r.vendor <= SCL_RST_VENDOR;
      st_r.device <= {SCL_RST_DEV_HIGH, 8'h00};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Output flops derived from latched state
  typedef struct packed {
    logic respond;
    logic oe_n;
    logic [7:0] int_pin;
    logic legacy_en;
    logic fc_mode;
    logic mm_mode;
    logic test;
    logic mem_off;
    logic cs_oe_n;
    logic agp;
    logic [1:0] gain;
    logic use_pll;
  } scl_out_s;

  scl_out_s out_r;
  scl_out_s out_nxt;

  // Decoded configuration, registered so every output is a flop
  always_comb begin
    out_nxt.respond = !st_r.device_disable_strap;
    // Own flop so the bus enable is not an inverter after a register
    out_nxt.oe_n = st_r.device_disable_strap;
    out_nxt.int_pin = st_r.interrupt_advertise_strap ?
      SCL_INT_PIN_NONE : SCL_INT_PIN_ADV;
    out_nxt.legacy_en = !st_r.legacy_off;
    out_nxt.fc_mode = !st_r.connector_class_sense;
    out_nxt.mm_mode = st_r.connector_class_sense;
    out_nxt.test = st_r.test_mode_strap;
    out_nxt.mem_off = st_r.config_status_word == SCL_MEM_OFF;
    // Chip selects float until a latched enable strap says otherwise
    out_nxt.cs_oe_n = !st_r.cs_en;
    out_nxt.agp = agp_now;
    out_nxt.gain = scl_gain_map(st_r.pll_gain_strap);
    // Normal choice: PLL on accelerated port, bus clock on PCI
    out_nxt.use_pll = agp_now ^ st_r.clk_choice;
  end

  // Output register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_r <= '0;
      out_r.respond <= 1'b1;
      out_r.int_pin <= SCL_RST_INT_PIN;
      out_r.legacy_en <= 1'b1;
      out_r.fc_mode <= 1'b1;
      out_r.cs_oe_n <= 1'b1;
      out_r.gain <= SCL_RST_PLL_GAIN;
    end else begin
      out_r <= out_nxt;
    end
  end

  // Port drive, straight from flops
  assign bus_rdata = st_r.rdata;
  assign straps_latched = st_r.st == SCL_ST_HELD;
  assign init_select = st_r.init_sel;
  assign host_respond_en = out_r.respond;
  assign host_bus_oe_n = out_r.oe_n;
  assign rom_addr_out = st_r.rom_addr;
  assign interrupt_pin_value = out_r.int_pin;
  assign intr_req = st_r.intr;
  assign legacy_display_en = out_r.legacy_en;
  assign feature_connector_mode = out_r.fc_mode;
  assign multimedia_connector = out_r.mm_mode;
  assign test_mode = out_r.test;
  assign bar_prefetchable = st_r.prefetch;
  assign mem_type = st_r.config_status_word;
  assign mem_access_off = out_r.mem_off;
  assign mem_cs_oe_n = out_r.cs_oe_n;
  assign bus_is_agp = out_r.agp;
  assign pll_gain_code = out_r.gain;
  assign writable_flash_present = st_r.flash;
  assign module_speed = st_r.speed;
  assign board_vendor_code = st_r.vendor;
  assign board_device_code = st_r.device;
  assign core_clk_from_pll = out_r.use_pll;

endmodule : scl_strap_latch

// >>> verification/scl_strap_latch_sva.sv
// Checker for the strap configuration latch ports
module scl_strap_latch_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Inputs watched
  input wire logic [63:0] memory_data_bus_in,
  input wire scl_pkg::scl_bus_req_s bus_req,
  input wire logic irq_event,
  // Outputs watched
  input wire logic [31:0] bus_rdata,
  input wire logic straps_latched,
  input wire logic init_select,
  input wire logic host_respond_en,
  input wire logic host_bus_oe_n,
  input wire logic [7:0] interrupt_pin_value,
  input wire logic legacy_display_en,
  input wire logic test_mode,
  input wire logic [2:0] mem_type,
  input wire logic mem_access_off,
  input wire logic mem_cs_oe_n,
  input wire logic [1:0] pll_gain_code,
  input wire logic [15:0] board_vendor_code,
  input wire logic [15:0] board_device_code,
  input wire logic intr_req
);
  timeunit 1ns;
  timeprecision 1ps;
  import scl_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Short alias for the strap bus
  logic [63:0] md;
  assign md = memory_data_bus_in;
  // Latched fields tied to the levels sampled at the latch edge
  a_mem_type_inv: assert property (
    $rose(straps_latched) |-> mem_type == ~$past(md[50:48]))
    else $error("memory type is not the inverse of straps");
  a_board_codes: assert property (
    $rose(straps_latched) |-> board_vendor_code == $past(md[23:8])
    && board_device_code[7:0] == $past(md[7:0]))
    else $error("board codes differ from straps");
  a_int_pin_val: assert property (
    $rose(straps_latched) |=> interrupt_pin_value ==
    ($past(md[59], 2) ? 8'h00 : 8'h01))
    else $error("interrupt pin value wrong");
  a_cs_enable: assert property (
    $rose(straps_latched) |=> mem_cs_oe_n == !$past(md[47], 2))
    else $error("chip select enable wrong");
  a_gain_map: assert property (
    $rose(straps_latched) |=> pll_gain_code ==
    {~$past(md[39], 2), $past(md[38], 2)})
    else $error("pll gain code wrong");
  // Once settled, decoded straps must not follow later bus traffic
  a_latch_holds: assert property (
    $past(straps_latched, 2) && straps_latched |-> $stable(test_mode)
    && $stable(legacy_display_en) && $stable(mem_cs_oe_n))
    else $error("latched strap output changed");
  a_oe_respond: assert property (
    host_bus_oe_n == !host_respond_en)
    else $error("host bus driven while not responding");
  a_select_off: assert property (
    !host_respond_en |=> !init_select)
    else $error("select asserted while disabled");
  a_mem_off: assert property (
    mem_access_off == ($past(mem_type) == 3'h7))
    else $error("memory access off flag wrong");
  a_intr_cause: assert property (
    intr_req |-> $past(irq_event) && host_respond_en)
    else $error("interrupt without cause or while disabled");
  a_int_pin_read: assert property (
    $past(bus_req.rd) && $past(bus_req.addr) == SCL_OFF_INT_PIN |->
    bus_rdata == {24'h0, interrupt_pin_value})
    else $error("interrupt pin read data wrong");
  // Main scenarios reached
  c_latched: cover property ($rose(straps_latched));
  c_intr: cover property (intr_req);
  c_disabled: cover property (!host_respond_en && straps_latched);
endmodule : scl_strap_latch_chk

bind scl_strap_latch scl_strap_latch_chk chk_u (
  .clk(clk), .rstn(rstn), .memory_data_bus_in(memory_data_bus_in),
  .bus_req(bus_req), .irq_event(irq_event), .bus_rdata(bus_rdata),
  .straps_latched(straps_latched), .init_select(init_select),
  .host_respond_en(host_respond_en), .host_bus_oe_n(host_bus_oe_n),
  .interrupt_pin_value(interrupt_pin_value),
  .legacy_display_en(legacy_display_en), .test_mode(test_mode),
  .mem_type(mem_type), .mem_access_off(mem_access_off),
  .mem_cs_oe_n(mem_cs_oe_n), .pll_gain_code(pll_gain_code),
  .board_vendor_code(board_vendor_code),
  .board_device_code(board_device_code), .intr_req(intr_req)
);

// >>> verification/scl_strap_model.sv
// Strap resistor model on the memory data bus and clock select pin
module scl_strap_model (
  // Clock
  input wire logic clk,
  // Fitted resistors, 1 = pull-up fitted
  input wire logic [63:0] pullups,
  input wire logic pin_pullup,
  // High once memory traffic owns the data bus
  input wire logic bus_busy,
  // Pin levels seen by the device
  output logic [63:0] md_level,
  output logic pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] churn_r = 64'h0;
  // Traffic flips bits 63..1 every cycle; bit 0 never flips and stays at its inverted strap level
  always @(posedge clk) churn_r <= ~churn_r ^ 64'h1;
  // Unfitted positions read zero through the internal pull-downs
  assign md_level = bus_busy ? (~pullups ^ churn_r) : pullups;
  assign pin_level = pin_pullup;
endmodule : scl_strap_model

// >>> verification/tb_top.sv
// Testbench for the strap configuration latch
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import scl_pkg::*;
  logic clk, rstn, pin_pu, busy, pin, pkg, cmd, irq;
  logic [63:0] pu, md;
  scl_host_sel_s sel;
  scl_bus_req_s req;
  logic [15:0] rom_in, rom_addr_out, board_vendor_code, board_device_code;
  logic [31:0] bus_rdata;
  logic [7:0] interrupt_pin_value;
  logic [2:0] mem_type, module_speed;
  logic [1:0] pll_gain_code;
  logic straps_latched, init_select, host_respond_en, host_bus_oe_n;
  logic intr_req, legacy_display_en, feature_connector_mode, test_mode;
  logic multimedia_connector, bar_prefetchable, mem_access_off;
  logic mem_cs_oe_n, bus_is_agp, writable_flash_present, core_clk_from_pll;
  int checked = 0;
  int num_errors = 0;
  int cyc = 0;

  scl_strap_model strap_u (.clk, .pullups(pu), .pin_pullup(pin_pu),
    .bus_busy(busy), .md_level(md), .pin_level(pin));
  scl_strap_latch dut_u (.clk, .rstn, .memory_data_bus_in(md),
    .bus_clock_choice_pin(pin), .pkg_is_bga(pkg), .host_cmd_start(cmd),
    .host_sel(sel), .rom_addr_in(rom_in), .irq_event(irq), .bus_req(req),
    .bus_rdata, .straps_latched, .init_select, .host_respond_en,
    .host_bus_oe_n, .rom_addr_out, .interrupt_pin_value, .intr_req,
    .legacy_display_en, .feature_connector_mode, .multimedia_connector,
    .test_mode, .bar_prefetchable, .mem_type, .mem_access_off,
    .mem_cs_oe_n, .bus_is_agp, .pll_gain_code, .writable_flash_present,
    .module_speed, .board_vendor_code, .board_device_code,
    .core_clk_from_pll);

  // Clock, 5 ns period
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Compare one value and count it
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] got);
    checked++;
    if (got !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, got);
    end
  endtask : chk

  // Register write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req <= '0;
  endtask : wr

  // Register read, data stands in the following cycle only
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string nm);
    @(posedge clk);
    req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    req <= '0;
    #1 chk(nm, e, bus_rdata);
  endtask : rd

  // One strap pattern from reset through latch, reads and firmware writes
  task automatic run(input int i);
    logic [7:0] b;
    logic [63:0] p;
    logic [1:0] gt [4];
    logic dis, agp, sel_exp;
    logic [2:0] mt;
    logic [31:0] sw, bid;
    b = {i[1:0], i[2] ^ i[0], i[1] ^ i[2], i[0], i[2:0]};
    p = {b, ~b, b, ~b, b, ~b, b, ~b};
    gt = '{2'h2, 2'h3, 2'h0, 2'h1};
    dis = p[51];
    agp = i[1] ^ p[40];
    // Sized on purpose: an inverted slice must not widen to 32 bits
    mt = ~p[50:48];
    sel_exp = dis ? 1'b0 : (agp ? (p[62] ? !i[1] : i[1]) : 1'b1);
    sw = {16'h0, p[31:29], p[37], p[39:38], p[40], p[47], p[51], p[53],
      p[55], p[57], p[58], p[59], p[61], p[62]};
    bid = {16'h5c3a, 16'hc3a5 ^ 16'(i)};
    @(posedge clk);
    pu <= p;
    pin_pu <= i[2];
    pkg <= i[1];
    busy <= 1'b0;
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    #1 chk("latched_rst", 0, straps_latched);
    wr(SCL_OFF_CFG_STATUS, 32'h5);
    @(posedge clk);
    cmd <= 1'b1;
    @(posedge clk);
    cmd <= 1'b0;
    busy <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("latched", 1, straps_latched);
    chk("mem_type", mt, mem_type);
    chk("mem_off", mt == SCL_MEM_OFF, mem_access_off);
    chk("int_pin", p[59] ? 8'h00 : 8'h01, interrupt_pin_value);
    chk("legacy", !p[58], legacy_display_en);
    chk("feature", !p[57], feature_connector_mode);
    chk("multimedia", p[57], multimedia_connector);
    chk("test", p[55], test_mode);
    chk("prefetch", p[53], bar_prefetchable);
    chk("respond", !dis, host_respond_en);
    chk("oe_n", dis, host_bus_oe_n);
    chk("cs_oe_n", !p[47], mem_cs_oe_n);
    chk("agp", agp, bus_is_agp);
    chk("gain", gt[p[39:38]], pll_gain_code);
    chk("flash", p[37], writable_flash_present);
    chk("speed", p[31:29], module_speed);
    chk("vendor", p[23:8], board_vendor_code);
    chk("device", {SCL_RST_DEV_HIGH, p[7:0]}, board_device_code);
    chk("clk_pll", agp ^ i[2], core_clk_from_pll);
    rd(SCL_OFF_CFG_STATUS, mt, "rd_mem_type");
    rd(SCL_OFF_STRAP_STAT, sw, "rd_straps");
    rd(SCL_OFF_AUX_STAT, {30'h0, agp, 1'b1}, "rd_aux");
    rd(SCL_OFF_INT_PIN, p[59] ? 0 : 1, "rd_int_pin");
    rd(SCL_OFF_MEM_BAR, {p[53], 3'h0}, "rd_bar");
    rd(8'h1c, 0, "rd_unmapped");
    @(posedge clk);
    cmd <= 1'b1;
    sel <= '{i[1], ~i[1], 1'b1};
    rom_in <= 16'he123;
    irq <= 1'b1;
    @(posedge clk);
    cmd <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("relatch", mt, mem_type);
    chk("select", sel_exp, init_select);
    chk("rom", (p[61] & p[58]) ? 16'h0123 : 16'he123, rom_addr_out);
    chk("intr_masked", 0, intr_req);
    wr(SCL_OFF_INT_CTRL, 32'h1 << SCL_INT_CTRL_EN_BIT);
    repeat (2) @(posedge clk);
    #1 chk("intr", !dis, intr_req);
    rd(SCL_OFF_INT_CTRL, 32'h1 << SCL_INT_CTRL_EN_BIT, "rd_int_en");
    wr(SCL_OFF_CFG_STATUS, i);
    wr(SCL_OFF_BOARD_ID, bid);
    rd(SCL_OFF_CFG_STATUS, i, "fw_mem_type");
    rd(SCL_OFF_BOARD_ID, bid, "rd_board");
    chk("fw_mem_out", i, mem_type);
    chk("fw_vendor", 16'hc3a5 ^ 16'(i), board_vendor_code);
    chk("fw_device", 16'h5c3a, board_device_code);
    @(posedge clk);
    irq <= 1'b0;
    $display("test pattern %0d done", i);
  endtask : run

  // Closing report and verdict
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Hang guard, far above the roughly 330 cycles the patterns need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      report_and_stop();
    end
  end

  // Main sequence: every memory type and gain code through eight patterns
  initial begin
    rstn = 1'b0;
    pu = '0;
    pin_pu = 1'b0;
    busy = 1'b0;
    pkg = 1'b0;
    cmd = 1'b0;
    irq = 1'b0;
    sel = '0;
    rom_in = '0;
    req = '0;
    for (int i = 0; i < 8; i++) begin
      run(i);
    end
    report_and_stop();
  end
endmodule : tb_top
